/* rtl/fwfl_top.sv */
// fwfl_top.sv: fast window fault latches, overvoltage and undervoltage status with summary
// assumes: comparator levels from another domain, register access as a byte port from the
// serial interface logic on clk_i; enables come from registers held elsewhere
// Overview of operation
// - undervoltage bits 1 and 0 latch a fault for channels 2 and 1 when below threshold.
// - overvoltage bit n latches a fault for channel n+1 when above threshold.
// - a set flag stays set after the voltage recovers.
// - a write of one clears an undervoltage flag only while the channel is above threshold.
// - a write of one clears an overvoltage flag only while the channel is below threshold.
// - a disabled undervoltage channel reads as zero.
// - a disabled overvoltage channel reads as zero.
// - overvoltage status is at 16h, upper four zero after reset, lower four from start-up.
// - undervoltage status is at 12h, bits 7 to 2 for channels 8 to 3, same behaviour.
// - summary bit 2 is the OR of overvoltage flags and bit 0 the OR of undervoltage flags.
`include "fwfl_regs.svh"
module fwfl_top
	import fwfl_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// comparator levels, bit n is channel n+1
	input wire logic [7:0] undervoltage_fast_flag_i,
	input wire logic [7:0] overvoltage_fast_flag_i,
	// enables from the enable registers
	input wire logic [7:0] undervoltage_irq_enable_i,
	input wire logic [7:0] overvoltage_irq_enable_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// status out
	output logic [7:0] summary_o
);
	logic [7:0] uv_s1_r;
	logic [7:0] uv_s2_r;
	logic [7:0] ov_s1_r;
	logic [7:0] ov_s2_r;
	logic [7:0] uv_raw;
	logic [7:0] ov_raw;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	wire uv_sel = (reg_addr_i == `FWFL_OFS_UV_STATUS);
	wire ov_sel = (reg_addr_i == `FWFL_OFS_OV_STATUS);
	wire sum_sel = (reg_addr_i == `FWFL_OFS_SUMMARY);
	fwfl_bank_if uv_if();
	fwfl_bank_if ov_if();
	// two stages: comparators are asynchronous to clk_i
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			uv_s1_r <= 8'h00;
			uv_s2_r <= 8'h00;
			ov_s1_r <= 8'h00;
			ov_s2_r <= 8'h00;
		end else begin
			uv_s1_r <= undervoltage_fast_flag_i;
			uv_s2_r <= uv_s1_r;
			ov_s1_r <= overvoltage_fast_flag_i;
			ov_s2_r <= ov_s1_r;
		end
	end
	assign uv_if.fault = uv_s2_r;
	assign ov_if.fault = ov_s2_r;
	// zero bits give no clear strobe
	assign uv_if.clr = (reg_wr_i && uv_sel) ? reg_wdata_i : 8'h00;
	assign ov_if.clr = (reg_wr_i && ov_sel) ? reg_wdata_i : 8'h00;
	assign uv_if.enable = undervoltage_irq_enable_i;
	assign ov_if.enable = overvoltage_irq_enable_i;
	fwfl_bank #(.START_MASK(~`FWFL_UV_FIXED_ZERO_MASK)) u_uv (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus(uv_if.bank),
		.raw_o(uv_raw)
	);
	fwfl_bank #(.START_MASK(~`FWFL_OV_FIXED_ZERO_MASK)) u_ov (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus(ov_if.bank),
		.raw_o(ov_raw)
	);
	// summary uses masked flags, matching what software reads
	wire [7:0] sum_nxt = {5'h00, |ov_if.flags, 1'b0, |uv_if.flags};
	assign rdata_nxt = uv_sel ? uv_if.flags :
		ov_sel ? ov_if.flags :
		sum_sel ? sum_nxt : 8'h00;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= 8'h00;
			summary_o <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
			summary_o <= sum_nxt;
		end
	end
	assign reg_rdata_o = rdata_r;

	property p_uv_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_raw[0] && uv_s2_r[0]) |=> uv_raw[0];
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("uv flag cleared while fault present");
	property p_ov_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[7] && ov_s2_r[7]) |=> ov_raw[7];
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("ov flag cleared while fault present");
	property p_uv_set;
		@(posedge clk_i) disable iff (!rst_n_i)
		uv_s2_r[1] |=> uv_raw[1];
	endproperty
	a_uv_set: assert property (p_uv_set) else $error("uv fault not latched");
	property p_ov_set;
		@(posedge clk_i) disable iff (!rst_n_i)
		ov_s2_r[6] |=> ov_raw[6];
	endproperty
	a_ov_set: assert property (p_ov_set) else $error("ov fault not latched");
	property p_sticky;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[2] && !(reg_wr_i && ov_sel && reg_wdata_i[2])) |=> ov_raw[2];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped on recovery");
	property p_w0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_raw[5] && reg_wr_i && uv_sel && !reg_wdata_i[5]) |=> uv_raw[5];
	endproperty
	a_w0: assert property (p_w0) else $error("write of zero cleared a flag");
	property p_clr;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[3] && !ov_s2_r[3] && reg_wr_i && ov_sel && reg_wdata_i[3]) |=> !ov_raw[3];
	endproperty
	a_clr: assert property (p_clr) else $error("write of one did not clear");
	property p_uv_mask;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_addr_i == 8'h12 && !undervoltage_irq_enable_i[4]) |=> !reg_rdata_o[4];
	endproperty
	a_uv_mask: assert property (p_uv_mask) else $error("disabled uv channel reads one");
	property p_ov_mask;
		@(posedge clk_i) disable iff (!rst_n_i)
		(reg_addr_i == 8'h16 && !overvoltage_irq_enable_i[1]) |=> !reg_rdata_o[1];
	endproperty
	a_ov_mask: assert property (p_ov_mask) else $error("disabled ov channel reads one");
	property p_sum;
		@(posedge clk_i) disable iff (!rst_n_i)
		1'b1 |=> (summary_o[2] == $past(|ov_if.flags)) && (summary_o[0] == $past(|uv_if.flags));
	endproperty
	a_sum: assert property (p_sum) else $error("summary mismatch");

	// latching on further channels: edge bits, plus uv bits 1 and 6
	property p_uv_hold1;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_raw[1] && uv_s2_r[1]) |=> uv_raw[1];
	endproperty
	a_uv_hold1: assert property (p_uv_hold1) else $error("uv flag 1 cleared under fault");
	property p_ov_hold0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[0] && ov_s2_r[0]) |=> ov_raw[0];
	endproperty
	a_ov_hold0: assert property (p_ov_hold0) else $error("ov flag 0 cleared under fault");
	property p_uv_set0;
		@(posedge clk_i) disable iff (!rst_n_i)
		uv_s2_r[0] |=> uv_raw[0];
	endproperty
	a_uv_set0: assert property (p_uv_set0) else $error("uv fault 0 not latched");
	property p_ov_set0;
		@(posedge clk_i) disable iff (!rst_n_i)
		ov_s2_r[0] |=> ov_raw[0];
	endproperty
	a_ov_set0: assert property (p_ov_set0) else $error("ov fault 0 not latched");
	property p_uv_set_hi;
		@(posedge clk_i) disable iff (!rst_n_i)
		uv_s2_r[7] |=> uv_raw[7];
	endproperty
	a_uv_set_hi: assert property (p_uv_set_hi) else $error("uv fault 7 not latched");
	property p_uv_sticky;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_raw[6] && !(reg_wr_i && uv_sel && reg_wdata_i[6])) |=> uv_raw[6];
	endproperty
	a_uv_sticky: assert property (p_uv_sticky) else $error("uv flag dropped on recovery");

	// clearing: ones clear a gone fault, zeros never clear
	property p_uv_clr;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_raw[2] && !uv_s2_r[2] && reg_wr_i && uv_sel && reg_wdata_i[2]) |=> !uv_raw[2];
	endproperty
	a_uv_clr: assert property (p_uv_clr) else $error("uv write of one did not clear");
	property p_ov_clr0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[0] && !ov_s2_r[0] && reg_wr_i && ov_sel && reg_wdata_i[0]) |=> !ov_raw[0];
	endproperty
	a_ov_clr0: assert property (p_ov_clr0) else $error("ov write of one did not clear");
	property p_ov_w0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_raw[4] && reg_wr_i && ov_sel && !reg_wdata_i[4]) |=> ov_raw[4];
	endproperty
	a_ov_w0: assert property (p_ov_w0) else $error("ov write of zero cleared a flag");

	// read path: enables hide latched flags, summary fixed bits stay low
	property p_uv_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		uv_sel |=> (reg_rdata_o == $past(uv_raw & undervoltage_irq_enable_i));
	endproperty
	a_uv_read: assert property (p_uv_read) else $error("uv status read mismatch");
	property p_ov_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		ov_sel |=> (reg_rdata_o == $past(ov_raw & overvoltage_irq_enable_i));
	endproperty
	a_ov_read: assert property (p_ov_read) else $error("ov status read mismatch");
	property p_uv_mask0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(uv_sel && !undervoltage_irq_enable_i[0]) |=> !reg_rdata_o[0];
	endproperty
	a_uv_mask0: assert property (p_uv_mask0) else $error("disabled uv channel 1 reads one");
	property p_ov_mask7;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ov_sel && !overvoltage_irq_enable_i[7]) |=> !reg_rdata_o[7];
	endproperty
	a_ov_mask7: assert property (p_ov_mask7) else $error("disabled ov channel 8 reads one");
	property p_sum_read;
		@(posedge clk_i) disable iff (!rst_n_i)
		sum_sel |=> (reg_rdata_o == {5'h00, $past(|ov_if.flags), 1'b0, $past(|uv_if.flags)});
	endproperty
	a_sum_read: assert property (p_sum_read) else $error("summary read mismatch");
	property p_sum_fixed;
		@(posedge clk_i) disable iff (!rst_n_i)
		(summary_o[7:3] == 5'h00) && !summary_o[1];
	endproperty
	a_sum_fixed: assert property (p_sum_fixed) else $error("summary fixed bit set");
endmodule

/* rtl/fwfl_regs.svh */
// fwfl_regs.svh: register offsets, field positions and reset values of the fast fault latches
// assumes: included by bare name from the design files
`ifndef FWFL_REGS_SVH
`define FWFL_REGS_SVH
`define FWFL_OFS_UV_STATUS 8'h12
`define FWFL_OFS_OV_STATUS 8'h16
`define FWFL_OFS_SUMMARY 8'h11
`define FWFL_SUM_OV_BIT 2
`define FWFL_SUM_UV_BIT 0
`define FWFL_OV_FIXED_ZERO_MASK 8'hF0
`define FWFL_UV_FIXED_ZERO_MASK 8'hF0
`define FWFL_NCH 8
`endif

/* rtl/fwfl_pkg.sv */
// fwfl_pkg.sv: types shared by the fast fault latches
// assumes: nothing beyond the header
package fwfl_pkg;
	typedef logic [7:0] fwfl_byte_t;
	typedef enum logic {FWFL_UNDER, FWFL_OVER} fwfl_kind_e;
endpackage

/* rtl/fwfl_if.sv */
// fwfl_if.sv: channel bank connection between the latch top and one latch bank
// assumes: one clock domain
interface fwfl_bank_if;
	logic [7:0] fault;
	logic [7:0] clr;
	logic [7:0] enable;
	logic [7:0] flags;
	modport bank (input fault, input clr, input enable, output flags);
	modport top (output fault, output clr, output enable, input flags);
endinterface

/* rtl/fwfl_bank.sv */
// fwfl_bank.sv: one bank of eight sticky write-one-to-clear fault flags
// assumes: fault inputs already synchronised to clk_i
module fwfl_bank
	import fwfl_pkg::*;
#(
	parameter logic [7:0] START_MASK = 8'h0F
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	fwfl_bank_if.bank bus,
	output logic [7:0] raw_o
);
	logic [7:0] flag_r;
	logic [7:0] flag_nxt;
	logic start_r;
	// clear only where condition gone; set wins over clear
	assign flag_nxt = (flag_r & ~(bus.clr & ~bus.fault)) | bus.fault;
	assign bus.flags = flag_r & bus.enable;
	assign raw_o = flag_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_r <= 8'h00;
			start_r <= 1'b1;
		end else if (start_r) begin
			// low flags capture start-up conditions after release
			flag_r <= bus.fault & START_MASK;
			start_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	property p_start_hi;
		@(posedge clk_i) disable iff (!rst_n_i)
		start_r |=> ((flag_r & ~START_MASK) == 8'h00);
	endproperty
	a_start_hi: assert property (p_start_hi) else $error("upper flag set at start-up");
endmodule

/* sim/fwfl_host.sv */
// fwfl_host.sv: register-port host model for the fast fault latches
// assumes: calls arrive on the falling edge of clk_i
module fwfl_host
	import fwfl_pkg::*;
(
	// clock
	input wire logic clk_i,
	// register port
	output logic wr_o,
	output fwfl_byte_t addr_o,
	output fwfl_byte_t wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// one-cycle strobe; ones ask for a clear, zeros leave bits alone
	task automatic wr(input fwfl_byte_t a, input fwfl_byte_t d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic point(input fwfl_byte_t a);
		@(negedge clk_i);
		addr_o = a;
	endtask
endmodule

/* sim/fast_window_fault_latches_tb.sv */
// fast_window_fault_latches_tb.sv: self-checking bench for fwfl_top
// assumes: fwfl_host drives the register port, bench drives levels
module fast_window_fault_latches_tb
	import fwfl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	fwfl_byte_t uv = 8'h00, ov = 8'h00, uv_en = 8'hFF, ov_en = 8'hFF;
	logic wr;
	fwfl_byte_t addr, wdata, rdata, summary;
	int n_errors = 0, n_checks = 0, cycles = 0;
	logic [8:0] q[$];
	logic [8:0] e;
	event got;
	always #4 clk_i = ~clk_i;
	fwfl_host host (.clk_i(clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
	fwfl_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .undervoltage_fast_flag_i(uv),
		.overvoltage_fast_flag_i(ov), .undervoltage_irq_enable_i(uv_en),
		.overvoltage_irq_enable_i(ov_en), .reg_wr_i(wr), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .summary_o(summary));
	task automatic final_report;
		if (n_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp_rdata(input fwfl_byte_t x);
		n_checks++;
		if (rdata !== x) begin
			$display("mismatch rdata expected %h seen %h", x, rdata);
			n_errors++;
		end
	endtask
	task automatic cmp_summary(input fwfl_byte_t x);
		n_checks++;
		if (summary !== x) begin
			$display("mismatch summary expected %h seen %h", x, summary);
			n_errors++;
		end
	endtask
	// watcher drains all notes: two triggers in one step would lose one
	always @(got) begin
		while (q.size() > 0) begin
			e = q.pop_front();
			if (e[8]) cmp_summary(e[7:0]);
			else cmp_rdata(e[7:0]);
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// address to registered data takes one edge
	task automatic rd(input fwfl_byte_t a, input fwfl_byte_t x);
		host.point(a);
		@(negedge clk_i);
		q.push_back({1'b0, x});
		->got;
	endtask
	task automatic sum(input logic k, input fwfl_byte_t v);
		q.push_back({1'b1, 5'h00, k & |v, 1'b0, ~k & |v});
		->got;
	endtask
	task automatic drv(input logic k, input fwfl_byte_t v);
		if (k) ov = v;
		else uv = v;
		cyc(5);
	endtask
	task automatic scen(input logic k);
		fwfl_byte_t a, m, w, f, en;
		a = k ? 8'h16 : 8'h12;
		m = 8'($urandom);
		w = 8'($urandom);
		f = m & 8'($urandom);
		en = 8'($urandom);
		drv(k, m);
		rd(a, m);
		sum(k, m);
		rd(8'h11, {5'h00, k & |m, 1'b0, ~k & |m});
		drv(k, 8'h00);
		rd(a, m);
		host.wr(a, w);
		cyc(3);
		rd(a, m & ~w);
		drv(k, f);
		host.wr(a, 8'hFF);
		cyc(3);
		rd(a, f);
		if (k) ov_en = en;
		else uv_en = en;
		cyc(2);
		rd(a, f & en);
		ov_en = 8'hFF;
		uv_en = 8'hFF;
		drv(k, 8'h00);
		host.wr(a, 8'hFF);
		cyc(3);
		rd(a, 8'h00);
	endtask
	initial begin
		void'($urandom(32'hB9EA4DB2));
		cyc(20);
		rst_n_i = 1'b1;
		cyc(2);
		rd(8'h16, 8'h00);
		rd(8'h12, 8'h00);
		sum(1'b0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			scen(i[0]);
		end
		cyc(2);
		final_report();
	end
endmodule
